// File: core/hbsb_bridge.sv
`timescale 1ns/1ns
module hbsb_bridge
  import hbsb_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  // Processor cycle inputs
  input  wire logic              CYCLE_START_STROBE_N,
  input  wire logic [BE_W-1:0]   BYTE_LANE_ENABLES_N,
  input  wire logic              HOST_MEMIO,
  input  wire logic              HOST_WRITE,
  input  wire logic              HOST_CACHEABLE_N,
  input  wire logic              HOST_LOCK_N,
  input  wire logic              L2_CLAIM,
  // Host address bus
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  output logic      [ADDR_W-1:0] ADDR_OUT,
  output logic                   ADDR_OE,
  // Host data bus
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   DATA_OE,
  // Processor control outputs
  output logic                   TRANSFER_READY_N,
  output logic                   PIPELINE_REQUEST_N,
  output logic                   CYCLE_ABORT_N,
  // Snoop signals
  output logic                   ADDR_BUS_HOLD,
  output logic                   SNOOP_STROBE_N,
  output logic                   CACHE_ALLOW_INVALIDATE,
  input  wire logic              SNOOP_DIRTY_HIT_N,
  // Forwarded read requests
  output logic                   FWD_REQ,
  output logic      [1:0]        FWD_TARGET,
  output logic      [ADDR_W-1:0] FWD_ADDR,
  output logic      [BE_W-1:0]   FWD_BE,
  output logic                   FWD_BURST,
  input  wire logic              FWD_RD_VALID,
  input  wire logic [DATA_W-1:0] FWD_RD_DATA,
  // Posted write drain
  output logic                   POST_VALID,
  input  wire logic              POST_READY,
  output logic      [1:0]        POST_TARGET,
  output logic      [ADDR_W-1:0] POST_ADDR,
  output logic      [BE_W-1:0]   POST_BE,
  output logic      [DATA_W-1:0] POST_DATA,
  // PCI master access to DRAM
  input  wire logic              PCI_DRAM_REQ,
  input  wire logic              PCI_DRAM_WRITE,
  input  wire logic [ADDR_W-1:0] PCI_DRAM_ADDR,
  input  wire logic              PCI_DRAM_DONE,
  output logic                   PCI_DRAM_GRANT,
  // Memory integrity mode
  output logic                   ECC_MODE
);

  hbsb_cpu_type    cpu_state;
  hbsb_snoop_type  snp_state;
  hbsb_target_type cyc_tgt;
  hbsb_target_type next_tgt;
  logic [ADDR_W-1:0]    cyc_addr;
  logic [BE_W-1:0]      cyc_be;
  logic                 cyc_burst;
  logic [1:0]           beat;
  logic [1:0]           last_beat;
  logic                 locked;
  logic                 wb_done;
  logic                 wb_seen;
  logic [4:0]           stall;
  logic [3:0]           snp_cnt;
  logic [3:0]           pci_dw;
  logic [3:0]           mem_qw;
  logic                 ads;
  logic                 room;
  logic                 push;
  logic                 pop;
  logic                 fifo_in_ready;
  logic                 do_abort;
  logic [PAYLOAD_W-1:0] push_word;
  logic [PAYLOAD_W-1:0] head_word;

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  assign ads       = !CYCLE_START_STROBE_N && !L2_CLAIM; // see R1 see R2 see R11
  assign next_tgt  = hbsb_route(HOST_MEMIO, ADDR_IN); // see R3 see R11
  assign last_beat = cyc_burst ? BURST_LAST : 2'h0;

  // ----------------------------------------
  // Posting buffer admission
  // ----------------------------------------
  always_comb begin
    if (cyc_tgt == TGT_PCI)
      room = (pci_dw <= 4'(PCI_POST_DWORDS - 2)); // see R13
    else
      room = (mem_qw < 4'(MERGE_QWORDS)); // see R14
  end

  // One push per beat; skip the cycle that shows ready
  assign push = (cpu_state == C_WRITE) && TRANSFER_READY_N && fifo_in_ready && room;
  assign pop  = POST_VALID && POST_READY;
  assign do_abort = (cpu_state == C_WRITE) && !push && (stall == ABORT_WAIT_CYC);

  assign push_word = {cyc_tgt, cyc_addr[ADDR_W-1:2], cyc_addr[1:0] ^ beat, cyc_be, DATA_IN};

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pci_dw <= 4'h0;
      mem_qw <= 4'h0;
    end else begin
      pci_dw <= pci_dw + ((push && cyc_tgt == TGT_PCI) ? 4'h2 : 4'h0)
                       - ((pop && POST_TARGET == TGT_PCI) ? 4'h2 : 4'h0);
      mem_qw <= mem_qw + 4'((push && cyc_tgt == TGT_DRAM))
                       - 4'((pop && POST_TARGET == TGT_DRAM));
    end
  end

  hbsb_fifo #(
    .WIDTH (PAYLOAD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_post (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (POST_VALID),
    .out_ready (POST_READY),
    .out_data  (head_word)
  );

  assign POST_TARGET = head_word[PAYLOAD_W-1 -: 2];
  assign POST_ADDR   = head_word[ADDR_W+BE_W+DATA_W-1 -: ADDR_W];
  assign POST_BE     = head_word[BE_W+DATA_W-1 -: BE_W];
  assign POST_DATA   = head_word[DATA_W-1:0];

  // ----------------------------------------
  // Processor cycle engine
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cpu_state          <= C_IDLE;
      cyc_tgt            <= TGT_DRAM;
      cyc_addr           <= '0;
      cyc_be             <= '0;
      cyc_burst          <= 1'b0;
      beat               <= 2'h0;
      TRANSFER_READY_N   <= 1'b1;
      PIPELINE_REQUEST_N <= 1'b1;
      DATA_OUT           <= '0;
      DATA_OE            <= 1'b0;
      FWD_REQ            <= 1'b0;
      FWD_TARGET         <= 2'h0;
      FWD_ADDR           <= '0;
      FWD_BE             <= '0;
      FWD_BURST          <= 1'b0;
      wb_done            <= 1'b0;
    end else begin
      TRANSFER_READY_N   <= 1'b1;
      PIPELINE_REQUEST_N <= 1'b1;
      FWD_REQ            <= 1'b0;
      wb_done            <= 1'b0;
      unique case (cpu_state)
        C_IDLE: begin
          DATA_OE <= 1'b0;
          beat    <= 2'h0;
          if (ads) begin
            cyc_tgt   <= next_tgt;
            cyc_addr  <= ADDR_IN;
            cyc_burst <= !HOST_CACHEABLE_N && HOST_MEMIO;
            // Cacheable reads and write-backs cover every lane
            cyc_be    <= HOST_CACHEABLE_N ? ~BYTE_LANE_ENABLES_N : 8'hff; // see R4
            if (next_tgt == TGT_CFG) begin
              cpu_state <= C_CFG;
            end else if (HOST_WRITE) begin
              cpu_state <= C_WRITE;
            end else begin
              cpu_state  <= C_READ; // see R11
              FWD_REQ    <= 1'b1;
              FWD_TARGET <= next_tgt;
              FWD_ADDR   <= ADDR_IN;
              FWD_BE     <= HOST_CACHEABLE_N ? ~BYTE_LANE_ENABLES_N : 8'hff; // see R4
              FWD_BURST  <= !HOST_CACHEABLE_N && HOST_MEMIO;
            end
          end
        end
        C_READ: begin
          DATA_OE <= 1'b1;
          if (FWD_RD_VALID) begin
            DATA_OUT         <= FWD_RD_DATA;
            TRANSFER_READY_N <= 1'b0; // see R5
            beat             <= beat + 2'h1;
            if (beat == last_beat) begin
              PIPELINE_REQUEST_N <= 1'b0; // see R6
              cpu_state          <= C_IDLE;
            end
          end
        end
        C_WRITE: begin
          if (do_abort) begin
            cpu_state <= C_IDLE; // see R9
          end else if (push) begin
            TRANSFER_READY_N <= 1'b0; // see R5
            beat             <= beat + 2'h1;
            if (beat == last_beat) begin
              PIPELINE_REQUEST_N <= 1'b0; // see R6
              wb_done            <= cyc_burst;
              cpu_state          <= C_IDLE;
            end
          end
        end
        C_CFG: begin
          DATA_OE          <= !HOST_WRITE;
          DATA_OUT         <= '0;
          DATA_OUT[CFG_ECC_BIT] <= ECC_MODE;
          TRANSFER_READY_N <= 1'b0; // see R5
          cpu_state        <= C_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Abort when a write stalls too long
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stall         <= 5'h0;
      CYCLE_ABORT_N <= 1'b1;
    end else begin
      CYCLE_ABORT_N <= !(do_abort && PCI_DRAM_REQ); // see R9
      if (cpu_state != C_WRITE || push || do_abort)
        stall <= 5'h0;
      else if (PCI_DRAM_REQ && !locked)
        stall <= stall + 5'h1;
    end
  end

  // ----------------------------------------
  // Integrity mode select
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N)
      ECC_MODE <= ECC_SEL_RESET; // see R15
    else if (cpu_state == C_CFG && HOST_WRITE)
      ECC_MODE <= DATA_IN[CFG_ECC_BIT]; // see R15
  end

  // ----------------------------------------
  // Lock tracking
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N)
      locked <= 1'b0;
    else if (ads && !HOST_LOCK_N)
      locked <= 1'b1; // see R17
    else if (HOST_LOCK_N && cpu_state == C_IDLE)
      locked <= 1'b0;
  end

  // ----------------------------------------
  // Snoop engine for PCI master DRAM access
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      snp_state              <= S_IDLE;
      snp_cnt                <= 4'h0;
      wb_seen                <= 1'b0;
      ADDR_BUS_HOLD          <= 1'b0;
      ADDR_OUT               <= '0;
      ADDR_OE                <= 1'b0;
      SNOOP_STROBE_N         <= 1'b1;
      CACHE_ALLOW_INVALIDATE <= 1'b0;
      PCI_DRAM_GRANT         <= 1'b0;
    end else begin
      SNOOP_STROBE_N         <= 1'b1;
      CACHE_ALLOW_INVALIDATE <= 1'b0; // see R16
      unique case (snp_state)
        S_IDLE: begin
          if (PCI_DRAM_REQ && !locked && cpu_state == C_IDLE && !ads) begin // see R17
            ADDR_BUS_HOLD <= 1'b1; // see R7
            snp_cnt       <= HOLD_SETUP_CYC;
            snp_state     <= S_HOLD;
          end
        end
        S_HOLD: begin
          snp_cnt <= snp_cnt - 4'h1;
          if (snp_cnt == 4'h1) begin
            ADDR_OUT               <= PCI_DRAM_ADDR; // see R3
            ADDR_OE                <= 1'b1; // see R3
            SNOOP_STROBE_N         <= 1'b0; // see R8 see R12
            CACHE_ALLOW_INVALIDATE <= PCI_DRAM_WRITE; // see R16
            snp_state              <= S_STROBE;
          end
        end
        S_STROBE: begin
          snp_cnt   <= SNOOP_DIRTY_HIT_N_WAIT_CYC;
          snp_state <= S_HIT;
        end
        S_HIT: begin
          snp_cnt <= snp_cnt - 4'h1;
          if (!SNOOP_DIRTY_HIT_N) begin
            // Free the bus so the dirty line can be written back
            ADDR_OE       <= 1'b0; // see R10
            ADDR_BUS_HOLD <= 1'b0;
            wb_seen       <= 1'b0;
            snp_state     <= S_WB;
          end else if (snp_cnt == 4'h1) begin
            PCI_DRAM_GRANT <= 1'b1; // see R12
            snp_state      <= S_GRANT;
          end
        end
        S_WB: begin
          if (wb_done)
            wb_seen <= 1'b1;
          if ((wb_seen || wb_done) && mem_qw == 4'h0 && cpu_state == C_IDLE && !ads) begin
            ADDR_BUS_HOLD  <= 1'b1; // see R7
            PCI_DRAM_GRANT <= 1'b1; // see R19
            snp_state      <= S_GRANT;
          end
        end
        S_GRANT: begin
          if (PCI_DRAM_DONE) begin
            PCI_DRAM_GRANT <= 1'b0;
            ADDR_BUS_HOLD  <= 1'b0; // see R20
            ADDR_OE        <= 1'b0; // see R20
            snp_state      <= S_IDLE;
          end
        end
        default: begin
          snp_state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// File: core/hbsb_fifo.sv
`timescale 1ns/1ns
module hbsb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // DEPTH must be a power of two so the pointers wrap
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-2:0]    wr_ptr;
  logic [CW-2:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready = (count != FULL);
  assign push     = in_valid && in_ready;
  assign pop      = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (CW-1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (CW-1)'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // Registered head word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

// File: core/hbsb_pkg.sv
// Overview of operation
// R1: Names ending _n are asserted low
// R2: Processor strobes cycle start with its attributes
// R3: Address lines input, driven during snoops
// R4: Cacheable reads return all eight byte lanes
// R5: One transfer ready per data transfer
// R6: Pipeline request before current cycle completes (code asserts it only together with the last transfer ready)
// R7: Hold address bus during PCI DRAM access
// R8: Snoop strobe inquires cache at driven address
// R9: Abort a stalled processor cycle when required
// R10: Processor flags dirty snoop hit, writes back
// R11: Forward non-cache cycles to DRAM, PCI, config
// R12: Route PCI master DRAM cycles with snooping
// R13: Six-doubleword posting limit for PCI writes
// R14: Eight-quadword limit for memory write buffer
// R15: Parity or correction selectable, parity at reset
// R16: Invalidate low for processor, per-kind on snoop
// R17: Locked sequences block PCI access to DRAM
// R18: Processor marks bursts with cacheable indication
// R19: Hold PCI access until write-back absorbed
// R20: Release hold and address after access completes
package hbsb_pkg;

  // ----------------------------------------
  // Widths and buffer sizes
  // ----------------------------------------
  localparam int ADDR_W          = 29;
  localparam int DATA_W          = 64;
  localparam int BE_W            = 8;
  localparam int PAYLOAD_W       = 2 + ADDR_W + BE_W + DATA_W;
  localparam int FIFO_DEPTH      = 32;
  localparam int PCI_POST_DWORDS = 6;
  localparam int MERGE_QWORDS    = 8;
  localparam logic [1:0] BURST_LAST = 2'h3;

  // ----------------------------------------
  // Timing counts in CORE_CLK cycles
  // ----------------------------------------
  localparam logic [3:0] HOLD_SETUP_CYC = 4'h2;
  localparam logic [3:0] SNOOP_DIRTY_HIT_N_WAIT_CYC  = 4'h2;
  localparam logic [4:0] ABORT_WAIT_CYC = 5'h10;

  // ----------------------------------------
  // Decode and reset values
  // ----------------------------------------
  localparam logic              ECC_SEL_RESET = 1'b0;
  localparam int                CFG_ECC_BIT   = 0;
  localparam logic [ADDR_W-1:0] CFG_ADDR      = 29'h0000019f;
  localparam logic [ADDR_W-1:0] DRAM_TOP      = 29'h02000000;

  typedef enum logic [1:0] {TGT_DRAM, TGT_PCI, TGT_CFG} hbsb_target_type;
  typedef enum logic [1:0] {C_IDLE, C_READ, C_WRITE, C_CFG} hbsb_cpu_type;
  typedef enum logic [2:0] {S_IDLE, S_HOLD, S_STROBE, S_HIT, S_WB, S_GRANT} hbsb_snoop_type;

  function automatic hbsb_target_type hbsb_route(input logic memio, input logic [ADDR_W-1:0] addr);
    if (!memio)
      hbsb_route = (addr == CFG_ADDR) ? TGT_CFG : TGT_PCI;
    else
      hbsb_route = (addr < DRAM_TOP) ? TGT_DRAM : TGT_PCI;
  endfunction

endpackage

// File: tb/hbsb_bridge_asserts.sv
`timescale 1ns/1ns
module hbsb_bridge_asserts
  import hbsb_pkg::*;
(
  // Clock and reset
  input wire logic              CORE_CLK,
  input wire logic              ARST_N,
  // Stimulus side
  input wire logic              PCI_DRAM_REQ,
  input wire logic              PCI_DRAM_WRITE,
  input wire logic [ADDR_W-1:0] PCI_DRAM_ADDR,
  input wire logic              PCI_DRAM_DONE,
  input wire logic              FWD_RD_VALID,
  input wire logic [DATA_W-1:0] FWD_RD_DATA,
  // Bridge outputs
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic              ADDR_OE,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic              DATA_OE,
  input wire logic              TRANSFER_READY_N,
  input wire logic              PIPELINE_REQUEST_N,
  input wire logic              CYCLE_ABORT_N,
  input wire logic              ADDR_BUS_HOLD,
  input wire logic              SNOOP_STROBE_N,
  input wire logic              CACHE_ALLOW_INVALIDATE,
  input wire logic              FWD_REQ,
  input wire logic [BE_W-1:0]   FWD_BE,
  input wire logic              FWD_BURST,
  input wire logic              PCI_DRAM_GRANT
);
  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  inv_cpu_low_a: assert property (SNOOP_STROBE_N |-> !CACHE_ALLOW_INVALIDATE)
    else $error("invalidate high outside snoop strobe");
  inv_kind_a: assert property (!SNOOP_STROBE_N |-> CACHE_ALLOW_INVALIDATE == PCI_DRAM_WRITE)
    else $error("invalidate does not follow snoop kind");
  snoop_addr_a: assert property (!SNOOP_STROBE_N |-> ADDR_BUS_HOLD && ADDR_OE && ADDR_OUT == PCI_DRAM_ADDR)
    else $error("snoop strobe without driven address");
  addr_drive_a: assert property (ADDR_OE |-> ADDR_BUS_HOLD)
    else $error("address driven without hold");
  grant_hold_a: assert property (PCI_DRAM_GRANT |-> ADDR_BUS_HOLD)
    else $error("grant without address hold");
  strobe_delay_a: assert property ($rose(ADDR_BUS_HOLD) && !PCI_DRAM_GRANT |-> ##2 !SNOOP_STROBE_N ##1 SNOOP_STROBE_N)
    else $error("snoop strobe not two cycles after hold");
  release_a: assert property (PCI_DRAM_GRANT && PCI_DRAM_DONE |=> !PCI_DRAM_GRANT && !ADDR_BUS_HOLD && !ADDR_OE)
    else $error("hold not released after done");
  pipe_ready_a: assert property (!PIPELINE_REQUEST_N |-> !TRANSFER_READY_N)
    else $error("pipeline request away from last ready");
  abort_pulse_a: assert property (!CYCLE_ABORT_N |-> $past(PCI_DRAM_REQ) ##1 CYCLE_ABORT_N)
    else $error("abort without pending access or too long");
  read_beat_a: assert property (FWD_RD_VALID && DATA_OE |=> !TRANSFER_READY_N && DATA_OUT == $past(FWD_RD_DATA))
    else $error("read beat not returned next cycle");
  line_lanes_a: assert property (FWD_REQ && FWD_BURST |-> FWD_BE == 8'hff)
    else $error("line fill without all lanes");
endmodule

bind hbsb_bridge hbsb_bridge_asserts u_chk (
  .CORE_CLK, .ARST_N, .PCI_DRAM_REQ, .PCI_DRAM_WRITE, .PCI_DRAM_ADDR, .PCI_DRAM_DONE,
  .FWD_RD_VALID, .FWD_RD_DATA, .ADDR_OUT, .ADDR_OE, .DATA_OUT, .DATA_OE, .TRANSFER_READY_N,
  .PIPELINE_REQUEST_N, .CYCLE_ABORT_N, .ADDR_BUS_HOLD, .SNOOP_STROBE_N, .CACHE_ALLOW_INVALIDATE,
  .FWD_REQ, .FWD_BE, .FWD_BURST, .PCI_DRAM_GRANT
);

// File: tb/hbsb_cpu_model.sv
`timescale 1ns/1ns
module hbsb_cpu_model
  import hbsb_pkg::*;
(
  // Clock and control
  input  wire logic              clk,
  input  wire logic              hit_en,
  // Processor pins
  output logic                   strobe_n,
  output logic      [BE_W-1:0]   be_n,
  output logic                   memio,
  output logic                   write,
  output logic                   cache_n,
  output logic                   lock_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] data,
  output logic                   hit_n,
  input  wire logic              ready_n,
  input  wire logic              abort_n,
  input  wire logic              snoop_n,
  input  wire logic [ADDR_W-1:0] a_bus,
  input  wire logic [DATA_W-1:0] d_bus
);
  logic [DATA_W-1:0] rdata = 64'h0;
  logic [ADDR_W-1:0] snp_a = 29'h0;
  logic              aborted = 1'b0;
  int                beats = 0;

  initial begin
    {strobe_n, cache_n, lock_n, hit_n, memio, write} = 6'h3c;
    {be_n, addr, data} = {8'hff, 29'h0, 64'h0};
  end

  // --------
  // One bus cycle
  // --------
  task automatic run(input logic wr, mio, cn, ln, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    int t;
    n = (mio && !cn) ? 4 : 1;
    t = 0;
    beats = 0;
    aborted = 1'b0;
    @(posedge clk);
    {strobe_n, write, memio, cache_n, lock_n} <= {1'b0, wr, mio, cn, ln};
    {addr, data, be_n} <= {a, d, 8'hfe};
    @(posedge clk);
    strobe_n <= 1'b1;
    while (beats < n && !aborted && t < 100) begin
      @(posedge clk);
      t++;
      if (!abort_n)
        aborted = 1'b1;
      if (!ready_n) begin
        rdata = d_bus;
        beats++;
        data <= d + 64'(beats);
      end
    end
    {addr, data, write, cache_n} <= {~a, ~d, 1'b0, 1'b1};
  endtask

  // --------
  // Inquire answer and write-back
  // --------
  initial forever begin
    @(posedge clk);
    if (!snoop_n)
      snp_a = a_bus;
    if (!snoop_n && hit_en) begin
      hit_n <= 1'b0;
      @(posedge clk);
      hit_n <= 1'b1;
      repeat (3) @(posedge clk);
      run(1'b1, 1'b1, 1'b0, 1'b1, snp_a, 64'h5a5a);
    end
  end
endmodule

// File: tb/host_bus_snoop_bridge_tb_top.sv
`timescale 1ns/1ns
module host_bus_snoop_bridge_tb_top
  import hbsb_pkg::*;
;
  logic              clk = 1'b0, arst_n = 1'b0, l2_claim = 1'b0, fwd_valid = 1'b0, post_ready = 1'b1;
  logic              req = 1'b0, req_wr = 1'b0, done = 1'b0, hit_en = 1'b0;
  logic [ADDR_W-1:0] req_addr = 29'h0;
  logic [DATA_W-1:0] fwd_data = 64'h0;
  logic              stb_n, mio, wr, cn, lock_n, hit_n, a_oe, d_oe, rdy_n, abort_n, hold, snoop_n;
  logic              f_req, f_burst, p_valid, grant, ecc;
  logic [1:0]        f_tgt;
  logic [BE_W-1:0]   be_n, f_be;
  logic [ADDR_W-1:0] c_addr, a_out, p_addr;
  logic [DATA_W-1:0] c_data, d_out, p_data;
  int                failures = 0, cmp_count = 0, drained = 0;
  wire  [ADDR_W-1:0] a_bus = a_oe ? a_out : c_addr;
  wire  [DATA_W-1:0] d_bus = d_oe ? d_out : c_data;

  hbsb_bridge u_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .CYCLE_START_STROBE_N(stb_n), .BYTE_LANE_ENABLES_N(be_n),
    .HOST_MEMIO(mio), .HOST_WRITE(wr), .HOST_CACHEABLE_N(cn), .HOST_LOCK_N(lock_n), .L2_CLAIM(l2_claim),
    .ADDR_IN(a_bus), .ADDR_OUT(a_out), .ADDR_OE(a_oe), .DATA_IN(d_bus), .DATA_OUT(d_out), .DATA_OE(d_oe),
    .TRANSFER_READY_N(rdy_n), .PIPELINE_REQUEST_N(), .CYCLE_ABORT_N(abort_n), .ADDR_BUS_HOLD(hold),
    .SNOOP_STROBE_N(snoop_n), .CACHE_ALLOW_INVALIDATE(), .SNOOP_DIRTY_HIT_N(hit_n), .FWD_REQ(f_req),
    .FWD_TARGET(f_tgt), .FWD_ADDR(), .FWD_BE(f_be), .FWD_BURST(f_burst), .FWD_RD_VALID(fwd_valid),
    .FWD_RD_DATA(fwd_data), .POST_VALID(p_valid), .POST_READY(post_ready), .POST_TARGET(), .POST_ADDR(p_addr),
    .POST_BE(), .POST_DATA(p_data), .PCI_DRAM_REQ(req), .PCI_DRAM_WRITE(req_wr), .PCI_DRAM_ADDR(req_addr),
    .PCI_DRAM_DONE(done), .PCI_DRAM_GRANT(grant), .ECC_MODE(ecc)
  );

  hbsb_cpu_model u_cpu (
    .clk(clk), .hit_en(hit_en), .strobe_n(stb_n), .be_n(be_n), .memio(mio), .write(wr), .cache_n(cn),
    .lock_n(lock_n), .addr(c_addr), .data(c_data), .hit_n(hit_n), .ready_n(rdy_n), .abort_n(abort_n),
    .snoop_n(snoop_n), .a_bus(a_bus), .d_bus(d_bus)
  );

  initial forever #10 clk = ~clk;

  always @(posedge clk) if (p_valid && post_ready) drained <= drained + 1;

  // --------
  // Forwarded read data source
  // --------
  initial forever begin
    @(posedge clk);
    if (f_req) begin
      for (int i = 0; i < (f_burst ? 4 : 1); i++) begin
        @(posedge clk);
        fwd_valid <= 1'b1;
        fwd_data <= 64'h00a5 + 64'(i);
      end
      @(posedge clk);
      fwd_valid <= 1'b0;
      fwd_data <= 64'hffff;
    end
  end

  // --------
  // Helpers
  // --------
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_grant(output int t);
    t = 0;
    while (grant !== 1'b1 && t < 60) begin
      tick(1);
      t++;
    end
  endtask

  task automatic pci(input logic w, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    {req, req_wr, req_addr} <= {1'b1, w, a};
  endtask

  task automatic pci_end;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    {done, req} <= 2'b00;
    #1;
    chk("grant_off", 0, grant);
    chk("hold_off", 0, hold);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    tick(8);
    chk("ready_rst", 1, rdy_n);
    chk("abort_rst", 1, abort_n);
    chk("snoop_rst", 1, snoop_n);
    chk("ecc_rst", 0, ecc);
    @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic t_cfg;
    u_cpu.run(1'b1, 1'b0, 1'b1, 1'b1, CFG_ADDR, 64'h1);
    tick(1);
    chk("ecc_set", 1, ecc);
    u_cpu.run(1'b0, 1'b0, 1'b1, 1'b1, CFG_ADDR, 64'h0);
    chk("cfg_read", 1, u_cpu.rdata[0]);
    u_cpu.run(1'b1, 1'b0, 1'b1, 1'b1, CFG_ADDR, 64'h0);
    tick(1);
    chk("ecc_clr", 0, ecc);
  endtask

  task automatic t_read;
    u_cpu.run(1'b0, 1'b1, 1'b0, 1'b1, 29'h100, 64'h0);
    chk("rd_beats", 4, u_cpu.beats);
    chk("rd_data", 64'h00a8, u_cpu.rdata);
    chk("rd_tgt", TGT_DRAM, f_tgt);
    chk("rd_be", 8'hff, f_be);
    u_cpu.run(1'b0, 1'b1, 1'b1, 1'b1, DRAM_TOP + 29'h5, 64'h0);
    chk("pci_beats", 1, u_cpu.beats);
    chk("pci_tgt", TGT_PCI, f_tgt);
    chk("pci_be", 8'h01, f_be);
  endtask

  task automatic t_merge;
    int base;
    @(posedge clk);
    post_ready <= 1'b0;
    for (int i = 0; i < MERGE_QWORDS; i++) begin
      u_cpu.run(1'b1, 1'b1, 1'b1, 1'b1, 29'h200 + 29'(i), 64'(i));
      chk("merge_acc", 1, u_cpu.beats);
    end
    base = drained;
    fork
      u_cpu.run(1'b1, 1'b1, 1'b1, 1'b1, 29'h2ff, 64'h9);
      begin
        tick(12);
        chk("merge_full", 0, u_cpu.beats);
        @(posedge clk);
        post_ready <= 1'b1;
      end
    join
    chk("merge_late", 1, u_cpu.beats);
    tick(30);
    chk("drained", base + 9, drained);
  endtask

  task automatic t_abort;
    int t;
    @(posedge clk);
    post_ready <= 1'b0;
    for (int i = 0; i < PCI_POST_DWORDS / 2; i++) begin
      u_cpu.run(1'b1, 1'b1, 1'b1, 1'b1, DRAM_TOP + 29'(i), 64'(i));
      chk("post_acc", 1, u_cpu.beats);
    end
    fork
      u_cpu.run(1'b1, 1'b1, 1'b1, 1'b1, DRAM_TOP + 29'h9, 64'h9);
      pci(1'b0, 29'h400);
    join
    chk("aborted", 1, u_cpu.aborted);
    chk("post_full", 0, u_cpu.beats);
    wait_grant(t);
    chk("abort_grant", 1, grant);
    pci_end();
    @(posedge clk);
    post_ready <= 1'b1;
  endtask

  task automatic t_snoop;
    int t;
    for (int k = 0; k < 2; k++) begin
      pci(k[0], 29'h500 + 29'(k));
      wait_grant(t);
      chk("grant_lat", 6, t);
      chk("snoop_addr", 29'h500 + 29'(k), a_out);
      pci_end();
    end
  endtask

  task automatic t_dirty;
    int t;
    @(posedge clk);
    {hit_en, post_ready} <= 2'b10;
    pci(1'b1, 29'h600);
    tick(40);
    chk("wb_wait", 0, grant);
    chk("wb_beats", 4, u_cpu.beats);
    chk("post_addr", 29'h600, p_addr);
    chk("post_data", 64'h5a5a, p_data);
    @(posedge clk);
    {hit_en, post_ready} <= 2'b01;
    wait_grant(t);
    chk("wb_grant", 1, grant);
    chk("wb_drained", 0, p_valid);
    pci_end();
  endtask

  task automatic t_lock;
    int t;
    u_cpu.run(1'b1, 1'b1, 1'b1, 1'b0, 29'h700, 64'h7);
    pci(1'b0, 29'h700);
    tick(12);
    chk("lock_hold", 0, hold);
    @(posedge clk);
    u_cpu.lock_n <= 1'b1;
    wait_grant(t);
    chk("unlock_grant", 1, grant);
    pci_end();
  endtask

  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    t_reset();
    t_cfg();
    t_read();
    t_merge();
    t_abort();
    t_snoop();
    t_dirty();
    t_lock();
    report_and_stop();
  end
endmodule
